// ---- sviu_core.sv ----
`timescale 1ns/1ps
`include "sviu_defs.svh"
module sviu_core
  import sviu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_irq_pin_a_n_i,
  input wire logic ext_irq_pin_b_n_i,
  input wire logic counter_a_ovf_i,
  input wire logic counter_b_ovf_i,
  input wire logic tick_base_i,
  input wire logic clock_tick_i,
  input wire logic cycle_phase_two_i,
  input wire logic stack_full_i,
  input wire logic return_from_irq_op_i,
  input wire logic halted_i,
  output logic irq_call_o,
  output logic [11:0] irq_vector_o,
  output logic wake_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic sviu_reg_t reg_decode(input logic [7:0] addr);
    sviu_reg_t r;
    r = SVIU_REG_NONE;
    if (addr == {`SVIU_IDX_CTRL_A, 2'b00}) begin
      r = SVIU_REG_CTRL_A;
    end else if (addr == {`SVIU_IDX_CTRL_B, 2'b00}) begin
      r = SVIU_REG_CTRL_B;
    end else if (addr == {`SVIU_IDX_EV_STAT, 2'b00}) begin
      r = SVIU_REG_EV_STAT;
    end else if (addr == {`SVIU_IDX_EV_MASK, 2'b00}) begin
      r = SVIU_REG_EV_MASK;
    end
    return r;
  endfunction

  function automatic sviu_src_t pick_source(input logic [5:0] pend);
    sviu_src_t s;
    s = SVIU_SRC_NONE;
    // lowest index wins: pin A highest, clock tick lowest
    for (int i = 5; i >= 0; i--) begin
      if (pend[i]) begin
        s = sviu_src_t'(i[2:0]);
      end
    end
    return s;
  endfunction

  function automatic logic [11:0] vector_of(input sviu_src_t s);
    logic [11:0] v;
    case (s)
      SVIU_SRC_PIN_A: v = `SVIU_VEC_PIN_A;
      SVIU_SRC_PIN_B: v = `SVIU_VEC_PIN_B;
      SVIU_SRC_CNT_A: v = `SVIU_VEC_CNT_A;
      SVIU_SRC_CNT_B: v = `SVIU_VEC_CNT_B;
      SVIU_SRC_TICK_BASE: v = `SVIU_VEC_TICK_BASE;
      SVIU_SRC_CLK_TICK: v = `SVIU_VEC_CLK_TICK;
      default: v = 12'h000;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // apb access
  // ---------------------------------------------------------------
  sviu_reg_t sel;
  logic apb_wr;
  logic apb_setup_rd;
  logic wr_a;
  logic wr_b;
  logic wr_stat;
  logic wr_mask;
  logic [7:0] wbyte;

  assign sel = reg_decode(paddr_i);
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign apb_setup_rd = psel_i & ~penable_i & ~pwrite_i;
  assign wbyte = pwdata_i[7:0];
  assign wr_a = apb_wr & pstrb_i[0] & (sel == SVIU_REG_CTRL_A);
  assign wr_b = apb_wr & pstrb_i[0] & (sel == SVIU_REG_CTRL_B);
  assign wr_stat = apb_wr & pstrb_i[0] & (sel == SVIU_REG_EV_STAT);
  assign wr_mask = apb_wr & pstrb_i[0] & (sel == SVIU_REG_EV_MASK);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & (sel == SVIU_REG_NONE);

  // ---------------------------------------------------------------
  // pin synchronisers and falling edge detect
  // ---------------------------------------------------------------
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [1:0] pin_prev_q;
  logic [1:0] pin_fall;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
      pin_prev_q <= 2'h3;
    end else begin
      pin_meta_q <= {ext_irq_pin_b_n_i, ext_irq_pin_a_n_i};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign pin_fall = pin_prev_q & ~pin_sync_q;

  // ---------------------------------------------------------------
  // enables, flags and service decision
  // ---------------------------------------------------------------
  logic master_q;
  logic [5:0] en_q;
  logic [5:0] flag_q;
  logic [5:0] flag_d;
  logic [5:0] ev_set;
  logic [5:0] pend_en;
  logic [5:0] svc_clr;
  logic take;
  logic blocked;
  sviu_src_t src;
  sviu_state_t state_q;

  assign ev_set = {clock_tick_i, tick_base_i, counter_b_ovf_i, counter_a_ovf_i,
                   pin_fall};
  assign pend_en = flag_q & en_q;
  assign src = pick_source(pend_en);
  // servicing only on the phase-two strobe keeps the core's call sequence aligned
  assign take = cycle_phase_two_i & master_q & ~stack_full_i & (|pend_en);
  assign blocked = cycle_phase_two_i & master_q & stack_full_i & (|pend_en);
  assign svc_clr = take ? (6'h01 << src) : 6'h00;

  generate
    for (genvar i = 0; i < 6; i++) begin : g_flag
      logic wr_hit;
      logic wr_val;
      if (i < 3) begin : g_a
        assign wr_hit = wr_a;
        assign wr_val = wbyte[`SVIU_A_FLAG_LSB + i];
      end else begin : g_b
        assign wr_hit = wr_b;
        assign wr_val = wbyte[`SVIU_B_FLAG_LSB + i - 3];
      end
      // a new event wins over a software or service clear
      assign flag_d[i] = ((wr_hit ? wr_val : flag_q[i]) & ~svc_clr[i]) | ev_set[i];
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= 6'h00;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 6'h00;
    end else begin
      if (wr_a) begin
        en_q[2:0] <= wbyte[`SVIU_A_EN_LSB +: 3];
      end
      if (wr_b) begin
        en_q[5:3] <= wbyte[`SVIU_B_EN_LSB +: 3];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      master_q <= 1'b0;
    end else if (take) begin
      master_q <= 1'b0;
    end else if (return_from_irq_op_i) begin
      master_q <= 1'b1;
    end else if (wr_a) begin
      master_q <= wbyte[`SVIU_A_MASTER];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SVIU_ST_IDLE;
    end else begin
      case (state_q)
        SVIU_ST_IDLE: begin
          if (take) begin
            state_q <= SVIU_ST_SERVICE;
          end
        end
        SVIU_ST_SERVICE: begin
          if (return_from_irq_op_i & ~take) begin
            state_q <= SVIU_ST_IDLE;
          end
        end
        default: state_q <= SVIU_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // call request to the sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_call_o <= 1'b0;
      irq_vector_o <= 12'h000;
    end else begin
      irq_call_o <= take;
      if (take) begin
        irq_vector_o <= vector_of(src);
      end
    end
  end

  // any enabled pending source wakes, master enable not needed
  assign wake_o = halted_i & (|pend_en);

  // ---------------------------------------------------------------
  // event status, mask and interrupt line
  // ---------------------------------------------------------------
  logic [2:0] ev_stat_q;
  logic [2:0] ev_mask_q;
  logic [2:0] ev_now;
  logic wake_prev_q;

  assign ev_now = {wake_o & ~wake_prev_q, blocked, take};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_prev_q <= 1'b0;
      ev_stat_q <= `SVIU_EV_RST;
    end else begin
      wake_prev_q <= wake_o;
      ev_stat_q <= (ev_stat_q & ~(wr_stat ? wbyte[2:0] : 3'h0)) | ev_now;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_mask_q <= `SVIU_EV_RST;
    end else if (wr_mask) begin
      ev_mask_q <= wbyte[2:0];
    end
  end

  assign irq_o = |(ev_stat_q & ev_mask_q);

  // ---------------------------------------------------------------
  // read data, captured in the setup phase
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (apb_setup_rd) begin
      case (sel)
        SVIU_REG_CTRL_A: prdata_o <= {24'h00_0000, 1'b0, flag_q[2:0], en_q[2:0],
                                      master_q};
        SVIU_REG_CTRL_B: prdata_o <= {24'h00_0000, 1'b0, flag_q[5:3], 1'b0,
                                      en_q[5:3]};
        SVIU_REG_EV_STAT: prdata_o <= {27'h000_0000, state_q == SVIU_ST_SERVICE,
                                       1'b0, ev_stat_q};
        SVIU_REG_EV_MASK: prdata_o <= {29'h0000_0000, ev_mask_q};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_call_follows_take;
    @(posedge sys_clk_i) disable iff (rst_i)
    take |=> irq_call_o ##1 (!irq_call_o || $past(take));
  endproperty
  a_call_follows_take: assert property (p_call_follows_take)
    else $error("call did not follow service decision");

  property p_master_cleared;
    @(posedge sys_clk_i) disable iff (rst_i)
    irq_call_o |-> !master_q;
  endproperty
  a_master_cleared: assert property (p_master_cleared)
    else $error("master enable still set after call");

  property p_full_stack_blocks;
    @(posedge sys_clk_i) disable iff (rst_i)
    stack_full_i && cycle_phase_two_i && !(take) |=> !irq_call_o;
  endproperty
  a_full_stack_blocks: assert property (p_full_stack_blocks)
    else $error("call issued with full stack");

  property p_full_stack_keeps_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
    blocked && pend_en[0] && !wr_a |=> flag_q[0];
  endproperty
  a_full_stack_keeps_flag: assert property (p_full_stack_keeps_flag)
    else $error("pending flag lost while stack full");

  property p_pin_a_vector;
    @(posedge sys_clk_i) disable iff (rst_i)
    take && pend_en[0] |=> irq_call_o && irq_vector_o == 12'h004;
  endproperty
  a_pin_a_vector: assert property (p_pin_a_vector)
    else $error("pin A vector wrong");

  property p_clk_tick_vector;
    @(posedge sys_clk_i) disable iff (rst_i)
    take && pend_en == 6'h20 |=> irq_vector_o == 12'h018;
  endproperty
  a_clk_tick_vector: assert property (p_clk_tick_vector)
    else $error("clock tick vector wrong");

  property p_flag_cleared_on_service;
    @(posedge sys_clk_i) disable iff (rst_i)
    take && pend_en[2] && pend_en[1:0] == 2'h0 && !counter_a_ovf_i && !wr_a
      |=> !flag_q[2];
  endproperty
  a_flag_cleared_on_service: assert property (p_flag_cleared_on_service)
    else $error("counter A flag not cleared on service");

  property p_return_from_irq_op_sets_master;
    @(posedge sys_clk_i) disable iff (rst_i)
    return_from_irq_op_i && !take |=> master_q;
  endproperty
  a_return_from_irq_op_sets_master: assert property (p_return_from_irq_op_sets_master)
    else $error("irq return did not set master enable");

  property p_disabled_no_call;
    @(posedge sys_clk_i) disable iff (rst_i)
    cycle_phase_two_i && (flag_q & en_q) == 6'h00 |=> !irq_call_o;
  endproperty
  a_disabled_no_call: assert property (p_disabled_no_call)
    else $error("call without enabled pending source");

  property p_counter_b_sets_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
    counter_b_ovf_i |=> flag_q[3];
  endproperty
  a_counter_b_sets_flag: assert property (p_counter_b_sets_flag)
    else $error("counter B overflow not flagged");

  property p_pin_fall_sets_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(pin_sync_q[1]) |-> ##1 flag_q[1];
  endproperty
  a_pin_fall_sets_flag: assert property (p_pin_fall_sets_flag)
    else $error("pin B falling edge not flagged");

  property p_unused_read_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    $past(apb_setup_rd) && $past(sel) == SVIU_REG_CTRL_B |-> !prdata_o[7] && !prdata_o[3];
  endproperty
  a_unused_read_zero: assert property (p_unused_read_zero)
    else $error("unused bit of register B read nonzero");

endmodule

// ---- sviu_defs.svh ----
`ifndef SVIU_DEFS_SVH
`define SVIU_DEFS_SVH
// Notes on behaviour
// - six sources: two pins, two counters, two ticks
// - two control registers at indices 0BH, 1EH
// - register A: master, three enables, three flags
// - register B: three enables, three flags, gaps zero
// - servicing clears master; new requests only flag
// - full stack blocks acknowledge; flag stays pending
// - every source can wake a halted core
// - push only program counter, then branch
// - falling pin edge sets its pin flag
// - pin vectors 04H and 08H, clear flag, master
// - counter A flag, vector 0CH, clears
// - counter B flag, vector 10H, clears
// - tick vectors 14H and 18H, clears
// - fixed priority pin A first, clock tick last
// - irq return sets master; plain return does not
// - service happens on phase-two strobe

// ---------------------------------------------------------------
// register indices; byte address is four times the index
// ---------------------------------------------------------------
`define SVIU_IDX_CTRL_A 6'h0B
`define SVIU_IDX_CTRL_B 6'h1E
`define SVIU_IDX_EV_STAT 6'h20
`define SVIU_IDX_EV_MASK 6'h21
`define SVIU_CTRL_RST 8'h00
`define SVIU_EV_RST 3'h0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SVIU_A_MASTER 0
`define SVIU_A_EN_LSB 1
`define SVIU_A_FLAG_LSB 4
`define SVIU_B_EN_LSB 0
`define SVIU_B_FLAG_LSB 4
`define SVIU_EV_SERVICED 0
`define SVIU_EV_BLOCKED 1
`define SVIU_EV_WAKE 2
`define SVIU_ST_IN_SERVICE 4

// ---------------------------------------------------------------
// branch vectors
// ---------------------------------------------------------------
`define SVIU_VEC_PIN_A 12'h004
`define SVIU_VEC_PIN_B 12'h008
`define SVIU_VEC_CNT_A 12'h00C
`define SVIU_VEC_CNT_B 12'h010
`define SVIU_VEC_TICK_BASE 12'h014
`define SVIU_VEC_CLK_TICK 12'h018
`endif

// ---- sviu_pkg.sv ----
package sviu_pkg;
  typedef enum logic [2:0] {
    SVIU_SRC_PIN_A = 3'b000,
    SVIU_SRC_PIN_B = 3'b001,
    SVIU_SRC_CNT_A = 3'b010,
    SVIU_SRC_CNT_B = 3'b011,
    SVIU_SRC_TICK_BASE = 3'b100,
    SVIU_SRC_CLK_TICK = 3'b101,
    SVIU_SRC_NONE = 3'b111
  } sviu_src_t;

  typedef enum logic [2:0] {
    SVIU_REG_CTRL_A = 3'b000,
    SVIU_REG_CTRL_B = 3'b001,
    SVIU_REG_EV_STAT = 3'b010,
    SVIU_REG_EV_MASK = 3'b011,
    SVIU_REG_NONE = 3'b111
  } sviu_reg_t;

  typedef enum logic [0:0] {
    SVIU_ST_IDLE = 1'b0,
    SVIU_ST_SERVICE = 1'b1
  } sviu_state_t;
endpackage

// ---- sviu_seq_model.sv ----
`timescale 1ns/1ps
module sviu_seq_model #(
  parameter int DEPTH = 6
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic irq_call_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic pop_irq_i,
  output logic stack_full_o,
  output logic return_from_irq_op_o,
  output logic cycle_phase_two_o
);
  int depth_q;
  logic [1:0] phase_q;
  // ---------------------------------------------------------------
  // sequencer phase
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign cycle_phase_two_o = (phase_q == 2'h3);
  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  // push onto a full stack loses the oldest entry, so depth saturates
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      depth_q <= 0;
    end else if ((irq_call_i || push_i) && !pop_i) begin
      depth_q <= (depth_q < DEPTH) ? depth_q + 1 : DEPTH;
    end else if (pop_i && !(irq_call_i || push_i) && depth_q > 0) begin
      depth_q <= depth_q - 1;
    end
  end
  assign stack_full_o = (depth_q >= DEPTH);
  assign return_from_irq_op_o = pop_i && pop_irq_i;
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "sviu_defs.svh"
module testbench;
  localparam logic [7:0] AD_A = {`SVIU_IDX_CTRL_A, 2'b00};
  localparam logic [7:0] AD_B = {`SVIU_IDX_CTRL_B, 2'b00};
  localparam logic [7:0] AD_S = {`SVIU_IDX_EV_STAT, 2'b00};
  localparam logic [7:0] AD_M = {`SVIU_IDX_EV_MASK, 2'b00};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic pin_a_n = 1'b1, pin_b_n = 1'b1, cnt_a = 1'b0, cnt_b = 1'b0;
  logic tick_b = 1'b0, clk_t = 1'b0, halted = 1'b0, push = 1'b0, pop = 1'b0, pop_irq = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, r;
  logic pready, pslverr, phase, sfull, return_from_irq_op, call, wake, irq, e, got;
  logic [11:0] vec, v;
  int fail_count = 0, checked = 0, cyc = 0, a_m, b_m, k;

  always #2.5 clk = ~clk;

  sviu_core DUT (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ext_irq_pin_a_n_i(pin_a_n), .ext_irq_pin_b_n_i(pin_b_n), .counter_a_ovf_i(cnt_a),
    .counter_b_ovf_i(cnt_b), .tick_base_i(tick_b), .clock_tick_i(clk_t),
    .cycle_phase_two_i(phase), .stack_full_i(sfull), .return_from_irq_op_i(return_from_irq_op),
    .halted_i(halted), .irq_call_o(call), .irq_vector_o(vec), .wake_o(wake), .irq_o(irq));

  sviu_seq_model seq (.sys_clk_i(clk), .rst_i(rst), .irq_call_i(call), .push_i(push),
    .pop_i(pop), .pop_irq_i(pop_irq), .stack_full_o(sfull),
    .return_from_irq_op_o(return_from_irq_op), .cycle_phase_two_o(phase));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task final_report;
    $display("mismatches=%0d comparisons=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp_reg(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task cmp_sig(input logic [11:0] g, input logic [11:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // pready high ends this wait; the bench timeout catches a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // idle cycle so the next call never reassigns a strobe in this step
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d));
  endtask
  task rdc(input logic [7:0] a, input int x);
    apb(1'b0, a, 32'h0);
    cmp_reg(r, 32'(x));
  endtask
  task fire(input int s);
    case (s)
      0: pin_a_n <= 1'b0;
      1: pin_b_n <= 1'b0;
      2: cnt_a <= 1'b1;
      3: cnt_b <= 1'b1;
      4: tick_b <= 1'b1;
      default: clk_t <= 1'b1;
    endcase
    @(posedge clk);
    {pin_a_n, pin_b_n, cnt_a, cnt_b, tick_b, clk_t} <= 6'h30;
  endtask
  task wait_call;
    int n;
    got = 1'b0;
    for (n = 0; n < 30 && !got; n++) begin
      @(posedge clk);
      if (call === 1'b1) begin
        got = 1'b1;
        v = vec;
      end
    end
  endtask
  task do_pop(input int n, input logic ri);
    pop <= 1'b1;
    pop_irq <= ri;
    repeat (n) @(posedge clk);
    pop <= 1'b0;
  endtask
  function automatic logic wk(int a, int b);
    return (((a >> 4) & (a >> 1) & 7) | ((b >> 4) & b & 7)) != 0;
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      final_report;
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    k = $urandom(13537);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(AD_A, 0);
    rdc(AD_B, 0);
    apb(1'b0, 8'h40, 32'h0);
    cmp_sig(12'(e), 12'h001);
    halted <= 1'b1;
    for (k = 0; k < 5; k++) begin
      a_m = (k == 0) ? 'hFE : ($urandom & 'hFE);
      b_m = (k == 0) ? 'hFF : ($urandom & 'hFF);
      wr(AD_A, a_m);
      wr(AD_B, b_m);
      rdc(AD_A, a_m & 'h7E);
      rdc(AD_B, b_m & 'h77);
      cmp_sig(12'(wake), 12'(wk(a_m, b_m)));
    end
    halted <= 1'b0;
    wr(AD_B, 0);
    wr(AD_A, 'h11);
    wait_call;
    cmp_sig(12'(got), 12'h000);
    rdc(AD_A, 'h11);
    for (k = 0; k < 6; k++) begin
      wr(AD_A, k < 3 ? (1 | (2 << k)) : 1);
      wr(AD_B, k < 3 ? 0 : (1 << (k - 3)));
      fire(k);
      wait_call;
      cmp_sig(12'(got), 12'h001);
      cmp_sig(v, 12'((k + 1) * 4));
      rdc(AD_A, k < 3 ? (2 << k) : 0);
      do_pop(1, !k[0]);
      rdc(AD_A, (k < 3 ? (2 << k) : 0) | (k[0] ? 0 : 1));
    end
    wr(AD_A, 'h7E);
    wr(AD_B, 'h77);
    wait_call;
    cmp_sig(12'(got), 12'h000);
    a_m = 'h7F;
    b_m = 'h77;
    wr(AD_A, a_m);
    for (k = 0; k < 6; k++) begin
      wait_call;
      cmp_sig(v, 12'((k + 1) * 4));
      if (k < 3) a_m &= ~(1 << (k + 4));
      else b_m &= ~(1 << (k + 1));
      a_m &= ~1;
      rdc(AD_A, a_m);
      rdc(AD_B, b_m);
      a_m |= 1;
      if (k[0]) begin
        do_pop(1, 1'b0);
        wr(AD_A, a_m);
      end else begin
        do_pop(1, 1'b1);
      end
    end
    push <= 1'b1;
    repeat (6) @(posedge clk);
    push <= 1'b0;
    wr(AD_A, 'h13);
    wait_call;
    cmp_sig(12'(got), 12'h000);
    rdc(AD_A, 'h13);
    do_pop(1, 1'b0);
    wait_call;
    cmp_sig(v, 12'h004);
    do_pop(6, 1'b0);
    apb(1'b0, AD_S, 32'h0);
    cmp_reg(r & 32'h1F, 32'h17);
    pstrb <= 4'hE;
    wr(AD_M, 7);
    pstrb <= 4'hF;
    rdc(AD_M, 0);
    wr(AD_M, 1);
    @(posedge clk);
    cmp_sig(12'(irq), 12'h001);
    wr(AD_S, 7);
    @(posedge clk);
    cmp_sig(12'(irq), 12'h000);
    final_report;
  end
endmodule
